/* shared/sto_pkg.sv */
// constants and types for the two-axis torque-off delay monitor
package sto_pkg;
    localparam int AXES = 2;
    localparam int CLK_NS = 50;
    localparam int TICK_MS = 100;
    localparam int TICK_NS = TICK_MS * 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int D1_MS = 1400;
    localparam int D2_MS = 2800;
    localparam int D3_MS = 5600;
    localparam int D4_MS = 9800;
    localparam int D5_MS = 30800;
    localparam logic [8:0] DT0 = 9'h000;
    localparam logic [8:0] DT1 = 9'(D1_MS / TICK_MS);
    localparam logic [8:0] DT2 = 9'(D2_MS / TICK_MS);
    localparam logic [8:0] DT3 = 9'(D3_MS / TICK_MS);
    localparam logic [8:0] DT4 = 9'(D4_MS / TICK_MS);
    localparam logic [8:0] DT5 = 9'(D5_MS / TICK_MS);
    localparam logic [2:0] DISC_TICKS = 3'h2;
    localparam logic [2:0] FB_TICKS = 3'h3;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] SEL_OFS = 12'h008;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int STAT_STO_POS = 0;
    localparam int STAT_FLT_POS = 2;
    localparam int STAT_MIS_POS = 4;
    localparam int STAT_INP_POS = 6;
    localparam int STAT_FB_POS = 8;
    localparam int STAT_MATCH_POS = 10;
    localparam int STAT_CAP_POS = 11;
    localparam int SEL_SEC_POS = 4;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01,
        ST_STO  = 2'b10
    } axis_state_t;

    function automatic logic [8:0] delay_ticks(input logic axis_b, input logic [3:0] code);
        logic [8:0] da;
        logic [8:0] db;
        da = DT0;
        db = DT0;
        case (code)
            4'h0: begin da = DT0; db = DT0; end
            4'h1: begin da = DT0; db = DT1; end
            4'h2: begin da = DT0; db = DT2; end
            4'h3: begin da = DT0; db = DT4; end
            4'h4: begin da = DT0; db = DT5; end
            4'h5: begin da = DT1; db = DT2; end
            4'h6: begin da = DT1; db = DT4; end
            4'h7: begin da = DT1; db = DT5; end
            4'h8: begin da = DT2; db = DT2; end
            4'h9: begin da = DT2; db = DT4; end
            4'hA: begin da = DT2; db = DT5; end
            4'hB: begin da = DT3; db = DT4; end
            4'hC: begin da = DT3; db = DT5; end
            4'hD: begin da = DT4; db = DT4; end
            4'hE: begin da = DT4; db = DT5; end
            default: begin da = DT5; db = DT5; end
        endcase
        return axis_b ? db : da;
    endfunction
endpackage

/* logic/tick_divider.sv */
// time base: one-cycle enable every N clocks
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int N = sto_pkg::TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output var  logic tick
);
    if (N < 2)
    begin : g_chk
        $error("tick divider needs N of at least 2");
    end

    logic [31:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 32'h0;
            tick  <= 1'b0;
        end
        else if (cnt_q == 32'(N - 1))
        begin
            cnt_q <= 32'h0;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule // tick_divider
`default_nettype wire

/* logic/delay_timer.sv */
// per-axis stop delay counter in time-base ticks
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
    parameter int W = 9
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] ticks,
    input  wire logic         tick,
    output var  logic         expired
);
    if (W < 9)
    begin : g_chk
        $error("delay timer too narrow for longest delay");
    end

    logic [W-1:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (load)
            cnt_q <= ticks;
        else if (tick && cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end

    assign expired = (cnt_q == '0);
endmodule // delay_timer
`default_nettype wire

/* logic/sto_delay_monitor.sv */
// two-axis safe torque-off delay monitor with apb status and control
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - separate indicator sets for axes A and B
// - restart indicator follows restart contact
// - shutdown indicators follow their switch contacts
// - torque-off indicator lit exactly in torque-off
// - safe-output indicators lit while outputs off
// - match indicator lit when selectors agree
// - fault indicator dark until fault found
// - fault indicator latches until power cycle
// - outputs drop after selected delay, or at once on a fault
// - selector disagreement raises a fault
// - selectors captured once at power-up
// - codes 0-4: A none, B 0..30.8s
// - codes 5-A: A 1.4s or 2.8s
// - codes B-F: A 5.6s, 9.8s, 30.8s
// - bad input wiring or order faults
// - bad amplifier feedback raises a fault
// - release only on restart close-to-open
// - second output always equals the first
module sto_delay_monitor #(
    parameter int TICK_CYCLES = sto_pkg::TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [1:0]  restart_input,
    input  wire logic [1:0]  first_shutdown_input,
    input  wire logic [1:0]  second_shutdown_input,
    input  wire logic [1:0]  torque_off_feedback,
    input  wire logic [3:0]  first_delay_selector,
    input  wire logic [3:0]  second_delay_selector,
    output var  logic [1:0]  first_safe_output,
    output var  logic [1:0]  second_safe_output,
    output var  logic [1:0]  led_restart,
    output var  logic [1:0]  led_shutdown1,
    output var  logic [1:0]  led_shutdown2,
    output var  logic [1:0]  led_sto,
    output var  logic [1:0]  led_out1,
    output var  logic [1:0]  led_out2,
    output var  logic [1:0]  selector_match_indicator,
    output var  logic [1:0]  led_fault,
    output var  logic [1:0]  led_power
);
    if (TICK_CYCLES < 2)
    begin : g_chk
        $error("TICK_CYCLES must be at least 2");
    end

    logic                  tick;
    logic                  cap_q;
    logic [3:0]            sel1_q;
    logic [3:0]            sel2_q;
    logic                  match_q;
    logic [1:0]            ctrl_q;
    sto_pkg::axis_state_t  state_q [2];
    logic [1:0]            fault_q;
    logic [1:0]            mis_q;
    logic [1:0]            inp_q;
    logic [1:0]            fb_q;
    logic [1:0]            restart_prev_q;
    logic [1:0]            restart_fall;
    logic [1:0]            expired;
    logic [1:0]            load;
    logic [1:0]            sd_open;
    logic [1:0]            sto_now;

    tick_divider #(
        .N (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // selectors read once; later turns of the switch are ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap_q   <= 1'b0;
            sel1_q  <= 4'h0;
            sel2_q  <= 4'h0;
            match_q <= 1'b0;
        end
        else if (!cap_q)
        begin
            cap_q   <= 1'b1;
            sel1_q  <= first_delay_selector;
            sel2_q  <= second_delay_selector;
            match_q <= (first_delay_selector == second_delay_selector);
        end
    end

    for (genvar g = 0; g < sto_pkg::AXES; g++)
    begin : g_axis
        logic [2:0] disc_q;
        logic [2:0] fbc_q;
        logic [8:0] dly;
        logic       req;
        logic       mis_d;
        logic       inp_d;
        logic       fb_d;

        assign dly = sto_pkg::delay_ticks(g == 1, sel1_q);
        assign restart_fall[g] = restart_prev_q[g] & ~restart_input[g];
        assign sd_open[g] = ~first_shutdown_input[g] | ~second_shutdown_input[g];
        assign sto_now[g] = (state_q[g] == sto_pkg::ST_STO);
        // any open contact or software request starts the stop
        assign req = sd_open[g] | ctrl_q[g];
        assign load[g] = (state_q[g] == sto_pkg::ST_RUN) && req;

        assign mis_d = cap_q & ~match_q;
        // restart released while shutdown contacts still open, or the two contacts disagree through DISC_TICKS ticks
        assign inp_d = (restart_fall[g] & sto_now[g] & sd_open[g])
                     | (tick && disc_q == sto_pkg::DISC_TICKS - 3'h1
                        && first_shutdown_input[g] != second_shutdown_input[g]);
        assign fb_d = tick && fbc_q == sto_pkg::FB_TICKS - 3'h1
                    && torque_off_feedback[g] != sto_now[g];

        delay_timer #(
            .W (9)
        ) u_dly (
            .pclk    (pclk),
            .presetn (presetn),
            .load    (load[g]),
            .ticks   (dly),
            .tick    (tick),
            .expired (expired[g])
        );

        // contacts may differ briefly while a two-channel switch moves
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                disc_q <= 3'h0;
            else if (first_shutdown_input[g] == second_shutdown_input[g])
                disc_q <= 3'h0;
            else if (tick && disc_q != sto_pkg::DISC_TICKS)
                disc_q <= disc_q + 3'h1;
        end

        // amplifier feedback lags our outputs; allow a few ticks
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                fbc_q <= 3'h0;
            else if (torque_off_feedback[g] == sto_now[g])
                fbc_q <= 3'h0;
            else if (tick && fbc_q != sto_pkg::FB_TICKS)
                fbc_q <= fbc_q + 3'h1;
        end

        // causes and fault latch; only reset clears them
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                mis_q[g]   <= 1'b0;
                inp_q[g]   <= 1'b0;
                fb_q[g]    <= 1'b0;
                fault_q[g] <= 1'b0;
            end
            else
            begin
                mis_q[g]   <= mis_q[g] | mis_d;
                inp_q[g]   <= inp_q[g] | inp_d;
                fb_q[g]    <= fb_q[g] | fb_d;
                fault_q[g] <= fault_q[g] | mis_d | inp_d | fb_d;
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                restart_prev_q[g] <= 1'b0;
            else
                restart_prev_q[g] <= restart_input[g];
        end

        // power-up lands in torque-off: driving needs a restart
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                state_q[g] <= sto_pkg::ST_STO;
            else if (fault_q[g])
                state_q[g] <= sto_pkg::ST_STO;
            else
            begin
                case (state_q[g])
                    sto_pkg::ST_RUN:
                        if (req && dly == sto_pkg::DT0)
                            state_q[g] <= sto_pkg::ST_STO;
                        else if (req)
                            state_q[g] <= sto_pkg::ST_STOP;
                    sto_pkg::ST_STOP:
                        if (expired[g])
                            state_q[g] <= sto_pkg::ST_STO;
                    sto_pkg::ST_STO:
                        if (restart_fall[g] && !sd_open[g] && !ctrl_q[g] && cap_q)
                            state_q[g] <= sto_pkg::ST_RUN;
                    default:
                        state_q[g] <= sto_pkg::ST_STO;
                endcase
            end
        end

        // contact closed means driving
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                first_safe_output[g]  <= 1'b0;
                second_safe_output[g] <= 1'b0;
            end
            else
            begin
                first_safe_output[g]  <= !sto_now[g];
                second_safe_output[g] <= !sto_now[g];
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                led_restart[g]              <= 1'b0;
                led_shutdown1[g]            <= 1'b0;
                led_shutdown2[g]            <= 1'b0;
                led_sto[g]                  <= 1'b0;
                led_out1[g]                 <= 1'b0;
                led_out2[g]                 <= 1'b0;
                selector_match_indicator[g] <= 1'b0;
                led_fault[g]                <= 1'b0;
                led_power[g]                <= 1'b0;
            end
            else
            begin
                led_restart[g]              <= restart_input[g];
                led_shutdown1[g]            <= first_shutdown_input[g];
                led_shutdown2[g]            <= second_shutdown_input[g];
                led_sto[g]                  <= sto_now[g];
                led_out1[g]                 <= sto_now[g];
                led_out2[g]                 <= sto_now[g];
                selector_match_indicator[g] <= cap_q & match_q;
                led_fault[g]                <= fault_q[g];
                led_power[g]                <= 1'b1;
            end
        end
    end

    // apb slave: one wait state, data and answer from flops
    logic        acc;
    logic        wr_now;
    logic [31:0] rdata;
    logic        hit;

    assign acc = psel & penable & ~pready;
    assign wr_now = psel & penable & pready & pwrite;

    always_comb
    begin
        rdata = 32'h0;
        hit = 1'b1;
        if (paddr == sto_pkg::CTRL_OFS)
            rdata[1:0] = ctrl_q;
        else if (paddr == sto_pkg::STAT_OFS)
        begin
            rdata[sto_pkg::STAT_STO_POS +: 2] = sto_now;
            rdata[sto_pkg::STAT_FLT_POS +: 2] = fault_q;
            rdata[sto_pkg::STAT_MIS_POS +: 2] = mis_q;
            rdata[sto_pkg::STAT_INP_POS +: 2] = inp_q;
            rdata[sto_pkg::STAT_FB_POS +: 2] = fb_q;
            rdata[sto_pkg::STAT_MATCH_POS] = match_q;
            rdata[sto_pkg::STAT_CAP_POS] = cap_q;
        end
        else if (paddr == sto_pkg::SEL_OFS)
        begin
            rdata[3:0] = sel1_q;
            rdata[sto_pkg::SEL_SEC_POS +: 4] = sel2_q;
        end
        else
            hit = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= acc;
            prdata  <= (acc && !pwrite) ? rdata : 32'h0;
            pslverr <= acc & ~hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= sto_pkg::CTRL_RST;
        else if (wr_now && paddr == sto_pkg::CTRL_OFS)
            ctrl_q <= pwdata[1:0];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    for (genvar a = 0; a < sto_pkg::AXES; a++)
    begin : g_chk_axis
        property p_out_pair;
            first_safe_output[a] == second_safe_output[a];
        endproperty
        a_out_pair: assert property (p_out_pair) else $error("safe outputs differ");

        property p_sto_led;
            led_power[a] |-> led_sto[a] == !first_safe_output[a] && led_out1[a] == led_sto[a];
        endproperty
        a_sto_led: assert property (p_sto_led) else $error("torque-off led disagrees");

        property p_fault_sticky;
            led_fault[a] |=> led_fault[a] [*8];
        endproperty
        a_fault_sticky: assert property (p_fault_sticky) else $error("fault led cleared");

        property p_fault_safe;
            fault_q[a] |-> ##2 !first_safe_output[a] && state_q[a] == sto_pkg::ST_STO;
        endproperty
        a_fault_safe: assert property (p_fault_safe) else $error("fault left output on");

        property p_restart_led;
            ##1 led_restart[a] == $past(restart_input[a]);
        endproperty
        a_restart_led: assert property (p_restart_led) else $error("restart led wrong");

        property p_release;
            $rose(first_safe_output[a]) |-> $past(restart_fall[a], 2);
        endproperty
        a_release: assert property (p_release) else $error("release without restart");

        property p_delay;
            state_q[a] == sto_pkg::ST_STOP ##1 state_q[a] == sto_pkg::ST_STO
                |-> $past(expired[a]) || $past(fault_q[a]);
        endproperty
        a_delay: assert property (p_delay) else $error("stop before delay");

        property p_mismatch;
            cap_q && !match_q |=> fault_q[a] ##1 led_fault[a];
        endproperty
        a_mismatch: assert property (p_mismatch) else $error("selector mismatch unflagged");

        c_fault: cover property (##1 $rose(led_fault[a]));
        c_release: cover property ($rose(first_safe_output[a]));
        c_delayed: cover property (state_q[a] == sto_pkg::ST_STOP ##1 state_q[a] == sto_pkg::ST_STO);
    end
endmodule // sto_delay_monitor
`default_nettype wire

/* verification/axis_partner.sv */
// behavioural safety switches and servo amplifiers for both axes
`timescale 1ns/1ps
`default_nettype none
module axis_partner (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] stop_req,
    input  wire logic [1:0] split,
    input  wire logic [1:0] fb_bad,
    input  wire logic [3:0] lag,
    input  wire logic [1:0] safe_out,
    output var  logic [1:0] first_sd,
    output var  logic [1:0] second_sd,
    output var  logic [1:0] fb
);
    logic [15:0] sh_q [2];

    // both contacts of an axis carry one state unless a split is ordered
    assign first_sd  = ~stop_req;
    assign second_sd = ~stop_req ^ split;

    // amplifier starts in torque-off, like the monitor after power-up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_q[0] <= 16'hFFFF;
            sh_q[1] <= 16'hFFFF;
        end
        else
        begin
            sh_q[0] <= {sh_q[0][14:0], ~safe_out[0]};
            sh_q[1] <= {sh_q[1][14:0], ~safe_out[1]};
        end
    end

    // lag stays well under the feedback tolerance; fb_bad models a broken line
    assign fb[0] = sh_q[0][lag] ^ fb_bad[0];
    assign fb[1] = sh_q[1][lag] ^ fb_bad[1];
endmodule // axis_partner
`default_nettype wire

/* verification/test_dual_axis_sto_delay_monitor.sv */
// self-checking bench for the two-axis torque-off delay monitor
`timescale 1ns/1ps
`default_nettype none
module test_dual_axis_sto_delay_monitor;
    localparam int TC = 10;
    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  restart;
    logic [1:0]  sd1;
    logic [1:0]  sd2;
    logic [1:0]  fb;
    logic [3:0]  sel1;
    logic [3:0]  sel2;
    logic [1:0]  so1;
    logic [1:0]  so2;
    logic [1:0]  l_rs, l_s1, l_s2, l_sto, l_o1, l_o2, l_m, l_f, l_p;
    logic [1:0]  stop_req;
    logic [1:0]  split;
    logic [1:0]  fb_bad;
    logic [3:0]  lag;
    logic [15:0] rnd;
    logic [1:0]  so1_prev;
    logic [32:0] an;
    int          cyc;
    int          miscompares;
    int          cmp_count;
    logic [63:0] qa [$];
    logic [63:0] qb [$];
    logic [32:0] aq [$];
    int          da [16] = '{0, 0, 0, 0, 0, 14, 14, 14, 28, 28, 28, 56, 56, 98, 98, 308};
    int          db [16] = '{0, 14, 28, 98, 308, 28, 98, 308, 28, 98, 308, 98, 308, 98, 308, 308};

    sto_delay_monitor #(.TICK_CYCLES(TC)) u_sto_delay_monitor (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .restart_input(restart), .first_shutdown_input(sd1), .second_shutdown_input(sd2),
        .torque_off_feedback(fb), .first_delay_selector(sel1), .second_delay_selector(sel2),
        .first_safe_output(so1), .second_safe_output(so2), .led_restart(l_rs),
        .led_shutdown1(l_s1), .led_shutdown2(l_s2), .led_sto(l_sto), .led_out1(l_o1),
        .led_out2(l_o2), .selector_match_indicator(l_m), .led_fault(l_f), .led_power(l_p));

    axis_partner u_axis_partner (
        .pclk(pclk), .presetn(presetn), .stop_req(stop_req), .split(split), .fb_bad(fb_bad),
        .lag(lag), .safe_out(so1), .first_sd(sd1), .second_sd(sd2), .fb(fb));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // window of cycles in which an axis output must fall
    task automatic note(input int i, input int lo, input int hi);
        if (i == 0)
            qa.push_back({32'(cyc + 1 + lo), 32'(cyc + 1 + hi)});
        else
            qb.push_back({32'(cyc + 1 + lo), 32'(cyc + 1 + hi)});
    endtask

    // free-running time base: up to one tick of phase is lost
    task automatic note_ticks(input int i, input int t);
        note(i, (t == 0) ? 2 : t * TC - TC, (t == 0) ? 2 : t * TC + 4);
    endtask

    task automatic fall(input int i);
        logic [63:0] w;
        if ((i == 0 && qa.size() == 0) || (i == 1 && qb.size() == 0))
            check("unexpected_stop", 32'h1, 32'h0);
        else
        begin
            w = (i == 0) ? qa.pop_front() : qb.pop_front();
            check("stop_time", cyc >= int'(w[63:32]) && cyc <= int'(w[31:0]), 1'b1);
        end
    endtask

    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while ((qa.size() + qb.size()) != 0 && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        check("notes_pending", qa.size() + qb.size(), 0);
        qa.delete();
        qb.delete();
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] ed,
                       input logic ee);
        aq.push_back({ed, ee});
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a hung access
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic boot(input logic [3:0] c1, input logic [3:0] c2);
        presetn <= 1'b0;
        sel1 <= c1;
        sel2 <= c2;
        stop_req <= 2'b00;
        split <= 2'b00;
        fb_bad <= 2'b00;
        restart <= 2'b00;
        rnd = lfsr(rnd);
        lag <= rnd[3:0];
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task automatic release_axes(input logic [1:0] exp);
        logic [1:0] b;
        b = so1;
        restart <= 2'b11;
        repeat (4) @(posedge pclk);
        check("restart_led", l_rs, 2'b11);
        check("no_release_on_close", so1, b);
        restart <= 2'b00;
        repeat (4) @(posedge pclk);
        check("restart_led_off", l_rs, 2'b00);
        check("release_out1", so1, exp);
        check("release_out2", so2, exp);
        check("sto_led", l_sto, 2'(~exp));
        check("out_led", {l_o2, l_o1}, {~exp, ~exp});
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk)
        cyc <= cyc + 1;

    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            if (aq.size() == 0)
                check("apb_unexpected", 32'h1, 32'h0);
            else
            begin
                an = aq.pop_front();
                check("prdata", prdata, an[32:1]);
                check("pslverr", pslverr, an[0]);
            end
        end
    end

    always @(negedge pclk)
    begin
        for (int i = 0; i < 2; i++)
            if (presetn === 1'b1 && so1_prev[i] === 1'b1 && so1[i] === 1'b0)
                fall(i);
        so1_prev = so1;
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        miscompares++;
        stop_test;
    end

    initial
    begin
        presetn = 1'b0;
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        restart = 2'b00;
        sel1 = 4'h0;
        sel2 = 4'h0;
        stop_req = 2'b00;
        split = 2'b00;
        fb_bad = 2'b00;
        lag = 4'h0;
        rnd = 16'h0047;
        so1_prev = 2'b00;
        cyc = 0;
        miscompares = 0;
        cmp_count = 0;
        @(posedge pclk);
        for (int c = 0; c < 16; c++)
        begin
            boot(4'(c), 4'(c));
            check("power_led", l_p, 2'b11);
            check("match_led", l_m, 2'b11);
            check("sd_led", {l_s2, l_s1}, 4'hF);
            release_axes(2'b11);
            note_ticks(0, da[c]);
            note_ticks(1, db[c]);
            stop_req <= 2'b11;
            wait_idle(3200);
            check("sd_led_open", {l_s2, l_s1}, 4'h0);
            check("fault_led", l_f, 2'b00);
            check("out_led_stop", {l_o2, l_o1}, 4'hF);
        end
        // selectors moved while powered must be ignored
        boot(4'h5, 4'h5);
        sel1 <= 4'h9;
        sel2 <= 4'hA;
        apb(12'h008, 1'b0, 32'h0, 32'h0000_0055, 1'b0);
        check("match_kept", l_m, 2'b11);
        apb(12'h00C, 1'b0, 32'h0, 32'h0, 1'b1);
        apb(12'h004, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b0);
        apb(12'h004, 1'b0, 32'h0, 32'h0000_0C03, 1'b0);
        release_axes(2'b11);
        rnd = lfsr(rnd);
        apb(12'h000, 1'b1, {rnd, 14'h0, 2'b01}, 32'h0, 1'b0);
        note_ticks(0, 14);
        wait_idle(400);
        release_axes(2'b10);
        apb(12'h000, 1'b1, 32'h0, 32'h0, 1'b0);
        release_axes(2'b11);
        // one contact of axis A opens alone
        note(0, TC, 3 * TC + 5);
        split <= 2'b01;
        wait_idle(100);
        repeat (20) @(posedge pclk);
        check("input_fault", l_f, 2'b01);
        split <= 2'b00;
        release_axes(2'b10);
        check("fault_held", l_f, 2'b01);
        // broken feedback line on axis B
        boot(4'h0, 4'h0);
        release_axes(2'b11);
        note(1, 2 * TC, 4 * TC + 5);
        fb_bad <= 2'b10;
        wait_idle(200);
        check("fb_fault", l_f, 2'b10);
        check("held_off", so1, 2'b01);
        // selectors disagree at power-up
        boot(4'h3, 4'h4);
        check("match_off", l_m, 2'b00);
        // fault latch trails the capture by one edge, its led by two
        @(posedge pclk);
        check("mismatch_fault", l_f, 2'b11);
        release_axes(2'b00);
        stop_test;
    end
endmodule // test_dual_axis_sto_delay_monitor
`default_nettype wire
